/* hw/boot_strap_pkg.sv */
// Types shared by the boot strap and reset control block.
package boot_strap_pkg;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_QUASI,
    ST_RUN
  } state_t;

  typedef enum logic [2:0] {
    PART_SINGLE,
    PART_SINGLE_LOW_LAT,
    PART_MULTI_UNATTACHED,
    PART_MULTI_DISABLED,
    PART_RESERVED
  } partition_t;

  typedef enum logic [1:0] {
    INIT_NONE,
    INIT_EEPROM,
    INIT_JUMP0,
    INIT_JUMP1
  } init_t;

endpackage

/* hw/boot_strap_regs.svh */
// Register offsets, field positions and reset values of the boot strap and reset control block.
`ifndef BOOT_STRAP_REGS_SVH
`define BOOT_STRAP_REGS_SVH

// =============================================================
// Register offsets
`define OFS_SWITCH_CTL 8'h00
`define OFS_PIN_FUNC   8'h04
`define OFS_PIN_DRIVE  8'h08
`define OFS_PIN_LEVEL  8'h0C
`define OFS_RED_EN     8'h10
`define OFS_RED_STATUS 8'h14
`define OFS_STRAPS     8'h18

// =============================================================
// Field positions
`define BIT_HOLD    0
`define POS_DRV_OUT 0
`define POS_DRV_OE  4
`define POS_ST_OP   0
`define POS_ST_CLK  4
`define POS_ST_FSEL 6
`define POS_ST_STK  7
`define POS_ST_HOLD 11
`define POS_ST_RESV 12

// =============================================================
// Pin function codes and reset values
`define FUNC_GPIO      2'h0
`define FUNC_ALT1      2'h1
`define FUNC_ALT2      2'h2
`define RST_PIN_FUNC   6'h00
`define RST_PIN_DRIVE  8'h00
`define RST_RED_EN     3'h0
`define REFCLK_SEL_125 1'h1

`endif

/* hw/switch_boot_strap_and_reset_ctl.sv */
// Boot strap capture, quasi-reset control and multipurpose pins 6 to 8.
// Contract
// - Pins run as GPIO or two alternates.
// - Pin change signals redundancy event when enabled.
// - Pin 6 is redundancy input 1 or 3.
// - Pin 7 redundancy 2 or port8 link-up out.
// - Pin 8 first alternate takes expander interrupt.
// - Pin 8 second alternate drives link-active out.
// - Four stack straps, each configures its stack.
// - Two-bit strap selects port clocking mode.
// - Frequency strap selects 100 or 125 MHz.
// - Fundamental reset low resets all logic.
// - Hold strap at reset enters quasi-reset.
// - Registers accessible while in quasi-reset.
// - Clearing hold bit starts normal operation.
// - Modes 0-3 are single partition variants.
// - Modes 4-7 reserved, not to be strapped.
// - Modes 8-9 single partition reduced latency.
// - Modes A-D multi-partition unattached variants.
// - Modes E-F multi-partition disabled variants.
`include "boot_strap_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module switch_boot_strap_and_reset_ctl (
  // Clock and reset
  input  wire logic                        SYS_CLK,
  input  wire logic                        RESET,
  // Board reset and straps
  input  wire logic                        FUNDAMENTAL_RESET_N,
  input  wire logic                        RESET_HOLD_STRAP,
  input  wire logic [3:0]                  SWITCH_OP_STRAP,
  input  wire logic [1:0]                  PORT_CLOCKING_STRAP,
  input  wire logic                        REFCLK_FREQ_STRAP,
  input  wire logic                        STACK0_CFG_STRAP,
  input  wire logic                        STACK1_CFG_STRAP,
  input  wire logic                        STACK2_CFG_STRAP,
  input  wire logic                        STACK3_CFG_STRAP,
  // Multipurpose pins 6, 7 and 8 at bits 0, 1 and 2
  input  wire logic [2:0]                  GPIO_PIN_IN,
  output logic      [2:0]                  GPIO_PIN_OUT,
  output logic      [2:0]                  GPIO_PIN_OE,
  // Port 8 link status from the port logic
  input  wire logic                        PORT8_LINK_UP,
  input  wire logic                        PORT8_LINK_ACTIVE,
  // Register port
  input  wire logic [7:0]                  REG_ADDR,
  input  wire logic [31:0]                 REG_WDATA,
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  output logic      [31:0]                 REG_RDATA,
  // Operating state and configuration to the core
  output logic                             QUASI_RESET,
  output logic                             CORE_RUN,
  output logic                             SMBUS_ENABLE,
  output var boot_strap_pkg::partition_t   PARTITION_MODE,
  output var boot_strap_pkg::init_t        INIT_MODE,
  output logic                             I2C_RESET_EN,
  output logic                             MODE_RESERVED,
  output logic                             REFCLK_IS_125,
  output logic      [1:0]                  PORT_CLOCKING_MODE,
  output logic      [3:0]                  STACK_CFG,
  // Events
  output logic      [2:0]                  REDUNDANCY_EVENT,
  output logic                             EXPANDER_IRQ_REQ
);

  // =============================================================
  // Pin synchronisers
  logic [15:0] sync1_reg;
  logic [15:0] sync2_reg;
  wire  [15:0] pins_w = {FUNDAMENTAL_RESET_N, RESET_HOLD_STRAP,
                         SWITCH_OP_STRAP, PORT_CLOCKING_STRAP,
                         REFCLK_FREQ_STRAP, STACK3_CFG_STRAP,
                         STACK2_CFG_STRAP, STACK1_CFG_STRAP,
                         STACK0_CFG_STRAP, GPIO_PIN_IN};

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
    end else begin
      sync1_reg <= pins_w;
      sync2_reg <= sync1_reg;
    end
  end

  wire       fund_sync_w = sync2_reg[15];
  wire       hold_sync_w = sync2_reg[14];
  wire [3:0] op_sync_w   = sync2_reg[13:10];
  wire [1:0] clk_sync_w  = sync2_reg[9:8];
  wire       fsel_sync_w = sync2_reg[7];
  wire [3:0] stk_sync_w  = sync2_reg[6:3];
  wire [2:0] pin_sync_w  = sync2_reg[2:0];

  // A synchronised low on the fundamental reset clears all state.
  wire in_reset_w = ~fund_sync_w;

  // =============================================================
  // Operating state
  boot_strap_pkg::state_t state_reg;
  boot_strap_pkg::state_t state_next;
  logic                   ctl_hold_reg;

  wire reg_ok_w   = (state_reg != boot_strap_pkg::ST_RESET);
  wire wr_w       = REG_WR && reg_ok_w;
  wire wr_ctl_w   = wr_w && (REG_ADDR == `OFS_SWITCH_CTL);
  wire wr_func_w  = wr_w && (REG_ADDR == `OFS_PIN_FUNC);
  wire wr_drive_w = wr_w && (REG_ADDR == `OFS_PIN_DRIVE);
  wire wr_en_w    = wr_w && (REG_ADDR == `OFS_RED_EN);
  wire wr_stat_w  = wr_w && (REG_ADDR == `OFS_RED_STATUS);
  wire hold_clr_w = wr_ctl_w && !REG_WDATA[`BIT_HOLD];
  wire release_w  = (state_reg == boot_strap_pkg::ST_RESET);

  // Leaving reset, the hold strap decides between quasi-reset and run.
  assign state_next =
    release_w ? (hold_sync_w ? boot_strap_pkg::ST_QUASI
                             : boot_strap_pkg::ST_RUN) :
    ((state_reg == boot_strap_pkg::ST_QUASI) && hold_clr_w) ?
      boot_strap_pkg::ST_RUN : state_reg;

  // The hold bit can only be cleared by software; setting it again has
  // no effect, so a running switch never drops back to quasi-reset.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state_reg    <= boot_strap_pkg::ST_RESET;
      ctl_hold_reg <= 1'b0;
    end else if (in_reset_w) begin
      state_reg    <= boot_strap_pkg::ST_RESET;
      ctl_hold_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ctl_hold_reg <= release_w ? hold_sync_w
                    : (hold_clr_w ? 1'b0 : ctl_hold_reg);
    end
  end

  // =============================================================
  // Strap capture
  logic [3:0] op_cap_reg;
  logic [1:0] clk_cap_reg;
  logic       fsel_cap_reg;
  logic [3:0] stk_cap_reg;
  logic       hold_cap_reg;

  // Sampled once at release so later strap motion cannot disturb the mode.
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      {op_cap_reg, clk_cap_reg, fsel_cap_reg, stk_cap_reg, hold_cap_reg} <= 12'h000;
    end else if (in_reset_w) begin
      {op_cap_reg, clk_cap_reg, fsel_cap_reg, stk_cap_reg, hold_cap_reg} <= 12'h000;
    end else if (release_w) begin
      {op_cap_reg, clk_cap_reg, fsel_cap_reg, stk_cap_reg, hold_cap_reg} <=
        {op_sync_w, clk_sync_w, fsel_sync_w, stk_sync_w, hold_sync_w};
    end
  end

  // =============================================================
  // Switch mode decode
  wire op_resv_w = (op_cap_reg[3:2] == 2'h1);

  boot_strap_pkg::partition_t part_w;
  boot_strap_pkg::init_t      init_w;

  assign part_w =
    !op_cap_reg[3]              ? (op_resv_w ? boot_strap_pkg::PART_RESERVED
                                             : boot_strap_pkg::PART_SINGLE) :
    (op_cap_reg[3:1] == 3'h4)   ? boot_strap_pkg::PART_SINGLE_LOW_LAT :
    (op_cap_reg[3:1] == 3'h7)   ? boot_strap_pkg::PART_MULTI_DISABLED :
                                  boot_strap_pkg::PART_MULTI_UNATTACHED;

  assign init_w =
    op_resv_w                   ? boot_strap_pkg::INIT_NONE :
    (op_cap_reg == 4'h2)        ? boot_strap_pkg::INIT_JUMP0 :
    (op_cap_reg == 4'h3)        ? boot_strap_pkg::INIT_JUMP1 :
    (op_cap_reg[3:1] == 3'h5)   ? boot_strap_pkg::INIT_NONE :
    (op_cap_reg[3:1] == 3'h6)   ? boot_strap_pkg::INIT_EEPROM :
    op_cap_reg[0]               ? boot_strap_pkg::INIT_EEPROM :
                                  boot_strap_pkg::INIT_NONE;

  wire i2c_rst_w = (op_cap_reg == 4'hB) || (op_cap_reg == 4'hD);

  // =============================================================
  // Software registers
  logic [5:0] func_reg;
  logic [7:0] drive_reg;
  logic [2:0] red_en_reg;
  logic [2:0] red_stat_reg;
  logic [2:0] red_prev_reg;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      {func_reg, drive_reg, red_en_reg} <= {`RST_PIN_FUNC, `RST_PIN_DRIVE, `RST_RED_EN};
    end else if (in_reset_w) begin
      {func_reg, drive_reg, red_en_reg} <= {`RST_PIN_FUNC, `RST_PIN_DRIVE, `RST_RED_EN};
    end else begin
      func_reg   <= wr_func_w  ? REG_WDATA[5:0] : func_reg;
      drive_reg  <= wr_drive_w ? REG_WDATA[7:0] : drive_reg;
      red_en_reg <= wr_en_w    ? REG_WDATA[2:0] : red_en_reg;
    end
  end

  // =============================================================
  // Pin function select
  logic [2:0][1:0] fsel_w;
  logic [2:0]      alt1_w;
  logic [2:0]      alt2_w;
  logic [2:0]      gpio_w;

  for (genvar i = 0; i < 3; i++) begin : g_fsel
    assign fsel_w[i] = func_reg[2*i +: 2];
    assign alt1_w[i] = (fsel_w[i] == `FUNC_ALT1);
    assign alt2_w[i] = (fsel_w[i] == `FUNC_ALT2);
    // The unused fourth code falls back to plain GPIO.
    assign gpio_w[i] = !alt1_w[i] && !alt2_w[i];
  end

  wire [2:0] drv_out_w = drive_reg[`POS_DRV_OUT +: 3];
  wire [2:0] drv_oe_w  = drive_reg[`POS_DRV_OE +: 3];

  // Alternates that are inputs leave the pin undriven.
  wire [2:0] out_next = {
    alt2_w[2] ? !PORT8_LINK_ACTIVE : (gpio_w[2] & drv_out_w[2]),
    alt2_w[1] ? !PORT8_LINK_UP     : (gpio_w[1] & drv_out_w[1]),
    gpio_w[0] & drv_out_w[0]};
  wire [2:0] oe_next = (gpio_w & drv_oe_w) | {alt2_w[2], alt2_w[1], 1'b0};

  // =============================================================
  // Redundancy event detection
  wire [2:0] red_src_w   = {pin_sync_w[0], pin_sync_w[1], pin_sync_w[0]};
  wire [2:0] red_route_w = {alt2_w[0], alt1_w[1], alt1_w[0]};
  // The previous level tracks the pin even when unrouted, so changing the
  // function select never fakes an edge.
  wire [2:0] red_evt_w   = red_route_w & red_en_reg
                         & (red_src_w ^ red_prev_reg);
  wire [2:0] red_clr_w   = wr_stat_w ? REG_WDATA[2:0] : 3'h0;

  // =============================================================
  // Read path
  wire [31:0] rd_mux_w =
    (REG_ADDR == `OFS_SWITCH_CTL) ? {31'h0, ctl_hold_reg} :
    (REG_ADDR == `OFS_PIN_FUNC)   ? {26'h0, func_reg} :
    (REG_ADDR == `OFS_PIN_DRIVE)  ? {24'h0, drive_reg} :
    (REG_ADDR == `OFS_PIN_LEVEL)  ? {29'h0, pin_sync_w} :
    (REG_ADDR == `OFS_RED_EN)     ? {29'h0, red_en_reg} :
    (REG_ADDR == `OFS_RED_STATUS) ? {29'h0, red_stat_reg} :
    (REG_ADDR == `OFS_STRAPS)     ? {19'h0, op_resv_w, hold_cap_reg, stk_cap_reg,
                                     fsel_cap_reg, clk_cap_reg, op_cap_reg} :
                                    32'h0000_0000;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= 32'h0000_0000;
    end else begin
      REG_RDATA <= (REG_RD && reg_ok_w) ? rd_mux_w : 32'h0000_0000;
    end
  end

  // =============================================================
  // Registered outputs
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      GPIO_PIN_OUT     <= 3'h0;
      GPIO_PIN_OE      <= 3'h0;
      REDUNDANCY_EVENT <= 3'h0;
      EXPANDER_IRQ_REQ <= 1'b0;
      QUASI_RESET      <= 1'b0;
      CORE_RUN         <= 1'b0;
      SMBUS_ENABLE     <= 1'b0;
      red_prev_reg     <= 3'h0;
      red_stat_reg     <= 3'h0;
    end else if (in_reset_w) begin
      GPIO_PIN_OUT     <= 3'h0;
      GPIO_PIN_OE      <= 3'h0;
      REDUNDANCY_EVENT <= 3'h0;
      EXPANDER_IRQ_REQ <= 1'b0;
      QUASI_RESET      <= 1'b0;
      CORE_RUN         <= 1'b0;
      SMBUS_ENABLE     <= 1'b0;
      red_prev_reg     <= 3'h0;
      red_stat_reg     <= 3'h0;
    end else begin
      GPIO_PIN_OUT     <= out_next;
      GPIO_PIN_OE      <= oe_next;
      REDUNDANCY_EVENT <= red_evt_w;
      EXPANDER_IRQ_REQ <= alt1_w[2] && !pin_sync_w[2];
      QUASI_RESET      <= (state_next == boot_strap_pkg::ST_QUASI);
      CORE_RUN         <= (state_next == boot_strap_pkg::ST_RUN);
      SMBUS_ENABLE     <= (state_next != boot_strap_pkg::ST_RESET);
      red_prev_reg     <= red_src_w;
      red_stat_reg     <= (red_stat_reg & ~red_clr_w) | red_evt_w;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      PARTITION_MODE     <= boot_strap_pkg::PART_SINGLE;
      INIT_MODE          <= boot_strap_pkg::INIT_NONE;
      I2C_RESET_EN       <= 1'b0;
      MODE_RESERVED      <= 1'b0;
      REFCLK_IS_125      <= 1'b0;
      PORT_CLOCKING_MODE <= 2'h0;
      STACK_CFG          <= 4'h0;
    end else begin
      PARTITION_MODE     <= part_w;
      INIT_MODE          <= init_w;
      I2C_RESET_EN       <= i2c_rst_w;
      MODE_RESERVED      <= op_resv_w;
      REFCLK_IS_125      <= (fsel_cap_reg == `REFCLK_SEL_125);
      PORT_CLOCKING_MODE <= clk_cap_reg;
      STACK_CFG          <= stk_cap_reg;
    end
  end

  // =============================================================
  // Assertions
  sequence seq_release;
    (state_reg == boot_strap_pkg::ST_RESET) && fund_sync_w;
  endsequence

  sequence seq_hold_clear;
    (state_reg == boot_strap_pkg::ST_QUASI) && fund_sync_w && hold_clr_w;
  endsequence

  AST_HOLD_ENTRY: assert property (@(posedge SYS_CLK) disable iff (RESET)
    seq_release ##0 hold_sync_w ##1 fund_sync_w |-> QUASI_RESET && SMBUS_ENABLE && ctl_hold_reg)
    else $error("hold strap did not enter quasi-reset");
  AST_NO_HOLD_RUN: assert property (@(posedge SYS_CLK) disable iff (RESET)
    seq_release ##0 !hold_sync_w ##1 fund_sync_w |-> CORE_RUN && !QUASI_RESET)
    else $error("release without hold did not run");
  AST_HOLD_EXIT: assert property (@(posedge SYS_CLK) disable iff (RESET)
    seq_hold_clear ##1 fund_sync_w |-> CORE_RUN && !ctl_hold_reg)
    else $error("clearing hold bit did not start operation");
  AST_FUND_RESET: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !fund_sync_w |=> !SMBUS_ENABLE && !CORE_RUN && (red_en_reg == 3'h0) && (GPIO_PIN_OE == 3'h0))
    else $error("fundamental reset did not clear state");
  AST_QUASI_READ: assert property (@(posedge SYS_CLK) disable iff (RESET)
    QUASI_RESET && fund_sync_w && REG_RD && (REG_ADDR == `OFS_SWITCH_CTL) |=> REG_RDATA[0])
    else $error("quasi-reset read of hold bit failed");
  AST_STRAP_HELD: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state_reg != boot_strap_pkg::ST_RESET) && fund_sync_w |=> $stable(op_cap_reg) && $stable(stk_cap_reg))
    else $error("strap capture changed outside release");
  AST_RED_EVENT: assert property (@(posedge SYS_CLK) disable iff (RESET)
    fund_sync_w && red_en_reg[0] && alt1_w[0] && (pin_sync_w[0] != red_prev_reg[0])
    |=> REDUNDANCY_EVENT[0] && red_stat_reg[0])
    else $error("redundancy edge lost");
  AST_RED_MASKED: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !red_en_reg[1] |=> !REDUNDANCY_EVENT[1])
    else $error("disabled redundancy input signalled");
  AST_LINK_UP_PIN: assert property (@(posedge SYS_CLK) disable iff (RESET)
    fund_sync_w && alt2_w[1] |=> GPIO_PIN_OE[1] && (GPIO_PIN_OUT[1] == !$past(PORT8_LINK_UP)))
    else $error("pin 7 link-up output wrong");
  AST_LINK_ACT_PIN: assert property (@(posedge SYS_CLK) disable iff (RESET)
    fund_sync_w && alt2_w[2] |=> GPIO_PIN_OE[2] && (GPIO_PIN_OUT[2] == !$past(PORT8_LINK_ACTIVE)))
    else $error("pin 8 link-active output wrong");
  AST_MODE_NINE: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (op_cap_reg == 4'h9) |=> (PARTITION_MODE == boot_strap_pkg::PART_SINGLE_LOW_LAT)
                          && (INIT_MODE == boot_strap_pkg::INIT_EEPROM))
    else $error("mode 9 decoded wrongly");

endmodule

`default_nettype wire

/* verification/board_strap_model.sv */
// Board side model: fundamental reset pin and strap levels of the switch.
`timescale 1ns/1ps
`default_nettype none

module board_strap_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Boot request and strap set {hold, stacks, freq, clocking, mode}
  input  wire logic        boot_req,
  input  wire logic [11:0] cfg,
  // Pins toward the switch
  output logic             fund_reset_n,
  output logic      [11:0] straps,
  output logic             boot_done
);
  logic [3:0] cnt_reg;

  // Straps move only while reset is low and settle 15 cycles before release,
  // well beyond the two cycles that the synchroniser needs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fund_reset_n <= 1'b0;
      straps       <= 12'h000;
      cnt_reg      <= 4'h0;
      boot_done    <= 1'b0;
    end else if (boot_req) begin
      fund_reset_n <= 1'b0;
      straps       <= cfg;
      cnt_reg      <= 4'hF;
      boot_done    <= 1'b0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == 4'h1) begin
        fund_reset_n <= 1'b1;
        boot_done    <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

/* verification/switch_boot_strap_and_reset_ctl_tb_top.sv */
// Self-checking bench for the boot strap and reset control block.
`include "boot_strap_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module switch_boot_strap_and_reset_ctl_tb_top;
  // =============================================================
  // Signals
  logic        SYS_CLK = 1'b0, RESET = 1'b1, boot_req = 1'b0, fund_n, boot_done;
  logic [11:0] cfg = 12'h000, straps;
  logic [2:0]  GPIO_PIN_IN = 3'h7, GPIO_PIN_OUT, GPIO_PIN_OE, REDUNDANCY_EVENT;
  logic        PORT8_LINK_UP = 1'b0, PORT8_LINK_ACTIVE = 1'b0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
  logic        REG_WR = 1'b0, REG_RD = 1'b0, QUASI_RESET, CORE_RUN, SMBUS_ENABLE;
  logic        I2C_RESET_EN, MODE_RESERVED, REFCLK_IS_125, EXPANDER_IRQ_REQ;
  logic [1:0]  PORT_CLOCKING_MODE;
  logic [3:0]  STACK_CFG;
  boot_strap_pkg::partition_t PARTITION_MODE;
  boot_strap_pkg::init_t      INIT_MODE;
  int          mismatches = 0, comparisons = 0, cycles = 0;

  always #5 SYS_CLK = ~SYS_CLK;

  board_strap_model board (.clk(SYS_CLK), .rst(RESET), .boot_req, .cfg, .fund_reset_n(fund_n), .straps,
                           .boot_done);

  switch_boot_strap_and_reset_ctl dut (.SYS_CLK, .RESET, .FUNDAMENTAL_RESET_N(fund_n),
    .RESET_HOLD_STRAP(straps[11]), .SWITCH_OP_STRAP(straps[3:0]), .PORT_CLOCKING_STRAP(straps[5:4]),
    .REFCLK_FREQ_STRAP(straps[6]), .STACK0_CFG_STRAP(straps[7]), .STACK1_CFG_STRAP(straps[8]),
    .STACK2_CFG_STRAP(straps[9]), .STACK3_CFG_STRAP(straps[10]), .GPIO_PIN_IN, .GPIO_PIN_OUT,
    .GPIO_PIN_OE, .PORT8_LINK_UP, .PORT8_LINK_ACTIVE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA, .QUASI_RESET, .CORE_RUN, .SMBUS_ENABLE, .PARTITION_MODE, .INIT_MODE, .I2C_RESET_EN,
    .MODE_RESERVED, .REFCLK_IS_125, .PORT_CLOCKING_MODE, .STACK_CFG, .REDUNDANCY_EVENT,
    .EXPANDER_IRQ_REQ);

  // =============================================================
  // Shared tasks
  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 chk(what, exp, REG_RDATA);
  endtask

  task automatic boot(input logic [11:0] c);
    int n;
    @(posedge SYS_CLK);
    cfg      <= c;
    boot_req <= 1'b1;
    @(posedge SYS_CLK);
    boot_req <= 1'b0;
    #1;
    for (n = 0; n < 40 && boot_done !== 1'b1; n++) @(posedge SYS_CLK) #1;
    repeat (6) @(posedge SYS_CLK);
    #1;
  endtask

  // Returns {partition, init, i2c reset, reserved} for a switch mode strap.
  function automatic logic [6:0] dec(input logic [3:0] m);
    logic [1:0] e;
    logic [1:0] u;
    e = m[0] ? boot_strap_pkg::INIT_EEPROM : boot_strap_pkg::INIT_NONE;
    u = m[2] ? boot_strap_pkg::INIT_EEPROM : boot_strap_pkg::INIT_NONE;
    if (m < 4'h4) return {boot_strap_pkg::PART_SINGLE, m[1:0], 2'b00};
    if (m < 4'h8) return {boot_strap_pkg::PART_RESERVED, boot_strap_pkg::INIT_NONE, 2'b01};
    if (m < 4'hA) return {boot_strap_pkg::PART_SINGLE_LOW_LAT, e, 2'b00};
    if (m < 4'hE) return {boot_strap_pkg::PART_MULTI_UNATTACHED, u, m[0], 1'b0};
    return {boot_strap_pkg::PART_MULTI_DISABLED, e, 2'b00};
  endfunction

  task automatic toggle(input int b, input logic [2:0] exp, input string what);
    logic [2:0] seen;
    seen = 3'h0;
    @(posedge SYS_CLK);
    GPIO_PIN_IN[b] <= ~GPIO_PIN_IN[b];
    for (int n = 0; n < 8 && seen == 3'h0; n++) @(posedge SYS_CLK) #1 seen = REDUNDANCY_EVENT;
    chk(what, exp, seen);
    @(posedge SYS_CLK);
    #1 chk(what, 3'h0, REDUNDANCY_EVENT);
  endtask

  // =============================================================
  // Scenarios
  task automatic sc_quasi();
    boot(12'h800);
    chk("quasi", 1'b1, QUASI_RESET);
    chk("run", 1'b0, CORE_RUN);
    chk("smbus", 1'b1, SMBUS_ENABLE);
    rd_chk("hold_bit", `OFS_SWITCH_CTL, 32'h1);
    reg_wr(`OFS_RED_EN, 32'h5);
    rd_chk("red_en", `OFS_RED_EN, 32'h5);
    rd_chk("unmapped", 8'h1C, 32'h0);
    reg_wr(`OFS_SWITCH_CTL, 32'h1);
    #1 chk("quasi_kept", 1'b1, QUASI_RESET);
    reg_wr(`OFS_SWITCH_CTL, 32'h0);
    @(posedge SYS_CLK);
    #1 chk("run_after_clear", 1'b1, CORE_RUN);
    chk("quasi_after_clear", 1'b0, QUASI_RESET);
    boot(12'h000);
    rd_chk("red_en_reset", `OFS_RED_EN, 32'h0);
  endtask

  task automatic sc_modes();
    logic [11:0] c;
    logic [6:0]  d;
    for (int i = 0; i < 16; i++) begin
      c = {1'b0, ~i[3:0], i[2], ~i[1:0], i[3:0]};
      d = dec(i[3:0]);
      boot(c);
      chk("partition", d[6:4], PARTITION_MODE);
      chk("init", d[3:2], INIT_MODE);
      chk("i2c_reset", d[1], I2C_RESET_EN);
      chk("reserved", d[0], MODE_RESERVED);
      chk("clocking", c[5:4], PORT_CLOCKING_MODE);
      chk("refclk", c[6], REFCLK_IS_125);
      chk("stacks", c[10:7], STACK_CFG);
      chk("run", 1'b1, CORE_RUN);
      rd_chk("straps", `OFS_STRAPS, {19'h0, d[0], c});
    end
  endtask

  task automatic sc_redundancy();
    reg_wr(`OFS_PIN_FUNC, 32'h05);
    reg_wr(`OFS_RED_EN, 32'h7);
    toggle(0, 3'h1, "redundancy_1");
    toggle(1, 3'h2, "redundancy_2");
    reg_wr(`OFS_PIN_FUNC, 32'h06);
    toggle(0, 3'h4, "redundancy_3");
    rd_chk("red_status", `OFS_RED_STATUS, 32'h7);
    reg_wr(`OFS_RED_STATUS, 32'h5);
    rd_chk("red_status_w1c", `OFS_RED_STATUS, 32'h2);
    reg_wr(`OFS_RED_EN, 32'h3);
    toggle(0, 3'h0, "redundancy_3_off");
    reg_wr(`OFS_PIN_FUNC, 32'h00);
    toggle(1, 3'h0, "pin7_gpio");
  endtask

  task automatic sc_pins();
    @(posedge SYS_CLK);
    PORT8_LINK_UP <= 1'b1;
    reg_wr(`OFS_PIN_FUNC, 32'h28);
    repeat (2) @(posedge SYS_CLK);
    #1 chk("oe_alt2", 3'h6, GPIO_PIN_OE);
    chk("out_alt2", 3'h4, GPIO_PIN_OUT & 3'h6);
    @(posedge SYS_CLK);
    PORT8_LINK_UP     <= 1'b0;
    PORT8_LINK_ACTIVE <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    #1 chk("out_alt2_flip", 3'h2, GPIO_PIN_OUT & 3'h6);
    reg_wr(`OFS_PIN_FUNC, 32'h10);
    GPIO_PIN_IN[2] <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    #1 chk("irq_low", 1'b1, EXPANDER_IRQ_REQ);
    chk("oe_alt1", 3'h0, GPIO_PIN_OE);
    @(posedge SYS_CLK);
    GPIO_PIN_IN[2] <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    #1 chk("irq_high", 1'b0, EXPANDER_IRQ_REQ);
    reg_wr(`OFS_PIN_FUNC, 32'h00);
    reg_wr(`OFS_PIN_DRIVE, 32'h75);
    repeat (2) @(posedge SYS_CLK);
    #1 chk("oe_gpio", 3'h7, GPIO_PIN_OE);
    chk("out_gpio", 3'h5, GPIO_PIN_OUT);
    rd_chk("levels", `OFS_PIN_LEVEL, {29'h0, GPIO_PIN_IN});
  endtask

  // =============================================================
  // Sequence and hang guard
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RESET <= 1'b0;
    sc_quasi();
    sc_modes();
    sc_redundancy();
    sc_pins();
    print_verdict();
  end

  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
endmodule

`default_nettype wire
